/* rtl/lwr_led_regs.sv */
// two-wire write-only target and register bank of a 28-channel led driver

// ---------------------------------------------------------------
// serial clock side: shifts data bits and hands over whole bytes
// ---------------------------------------------------------------
module lwr_link
	import lwr_pkg::*;
(
	input wire logic i_scl,
	input wire logic i_clr,
	input wire logic i_sda,
	output logic [7:0] o_byte,
	output logic o_toggle
);

	typedef struct packed {
		logic [6:0] shift;
		logic [3:0] cnt;
		logic [7:0] byte_r;
		logic tog;
	} lwr_link_s;

	lwr_link_s r;
	lwr_link_s nxt;

	// bit counter runs 0..7 for data, 8 for the acknowledge clock
	always_comb
	begin
		nxt = r;
		if (r.cnt == ACK_BIT)
		begin
			nxt.cnt = 4'h0;
		end
		else
		begin
			nxt.cnt = r.cnt + 4'h1;
			nxt.shift = {r.shift[5:0], i_sda};
			if (r.cnt == LAST_BIT)
			begin
				// word stays put for nine clocks, safe to read across
				nxt.byte_r = {r.shift, i_sda};
				nxt.tog = ~r.tog;
			end
		end
	end

	// cleared by start so a frame always begins at bit 0
	always_ff @(posedge i_scl or posedge i_clr)
	begin
		if (i_clr)
			r <= '0;
		else
			r <= nxt;
	end

	assign o_byte = r.byte_r;
	assign o_toggle = r.tog;

endmodule

// ---------------------------------------------------------------
// system clock side: protocol, register bank and channel outputs
// ---------------------------------------------------------------
// Operation
// - Answer only to address 01111 plus two strap bits, direction bit last.
// - Strap to ground, supply, clock or data gives 00, 11, 01, 10.
// - Writes only; a read request gets no acknowledge and is ignored.
// - Data bits are taken while the serial clock is high.
// - A start, data falling with clock high, begins address matching.
// - On address match, hold data low through the acknowledge clock.
// - Register-address byte follows, msb first, and is acknowledged.
// - Every data byte, msb first, is acknowledged.
// - Stop, data rising with clock high, ends the write.
// - Pointer steps by one at each data byte acknowledge; the code holds it at FFh instead of stepping past it.
// - Register 00h bit 0 is shutdown control, zero means shutdown.
// - 28 duty registers at 05h..20h, reset to zero.
// - Channel on time is duty over 256; zero keeps it off.
// - Writing register 25h moves pending duty and control to live copies.
// - Duty and control writes stay pending until 25h gets all zeros.
// - 28 channel control registers at 2Ah..45h.
// - Control bits 2:1 select current scale, bit 0 turns channel on.
// - Global enable at 4Ah, reset zero, gates all channels.
// - Register 4Fh returns every register to its default.
// - Soft reset needs all zeros written; power-up also resets.
// - Shutdown forces channels off while registers keep contents.
module lwr_led_regs
	import lwr_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic i_addr_sel,
	input wire logic i_hw_shutdown_pin_n,
	output logic [NUM_CH-1:0] o_led_channel_outputs,
	output logic [2*NUM_CH-1:0] o_current_scale_sel
);

	typedef struct packed {
		lwr_st_e st;
		lwr_kind_e kind;
		logic scl_m;
		logic scl_s;
		logic sda_m;
		logic sda_s;
		logic sda_d;
		logic sel_m;
		logic sel_s;
		logic hw_m;
		logic hw_s;
		logic tog_m;
		logic tog_s;
		logic tog_d;
		logic clr;
		logic sda_oe;
		logic seen_lo;
		logic seen_hi;
		logic ne_sda;
		logic [7:0] ptr;
		logic sw_shutdown_n;
		logic gen;
		logic [NUM_CH-1:0][7:0] duty_p;
		logic [NUM_CH-1:0][7:0] duty_a;
		logic [NUM_CH-1:0][2:0] ctl_p;
		logic [NUM_CH-1:0][2:0] ctl_a;
		logic [7:0] pwm_cnt;
		logic [NUM_CH-1:0] led;
		logic [NUM_CH-1:0][1:0] scale;
	} lwr_state_s;

	lwr_state_s r_r;
	lwr_state_s r_nxt;
	logic [7:0] link_byte;
	logic link_tog;
	logic link_clr;
	logic start_det;
	logic stop_det;
	logic new_byte;
	logic [1:0] ad_bits;
	logic addr_ok;
	logic wr_en;
	logic [4:0] duty_idx;
	logic [4:0] ctl_idx;
	logic outputs_on;

	// link logic held clear through reset and from start to first low clock
	assign link_clr = i_rst | r_r.clr;

	lwr_link u_link (
		.i_scl(i_scl),
		.i_clr(link_clr),
		.i_sda(i_sda),
		.o_byte(link_byte),
		.o_toggle(link_tog)
	);

	// ---------------------------------------------------------------
	// bus conditions seen on the synchronised pins
	// ---------------------------------------------------------------
	assign start_det = r_r.scl_s & r_r.sda_d & ~r_r.sda_s;
	assign stop_det = r_r.scl_s & ~r_r.sda_d & r_r.sda_s;
	// toggle ignored while clearing: the link counter restarts then
	assign new_byte = ~r_r.clr & (r_r.tog_s ^ r_r.tog_d);

	// strap class from how the pin moved since start
	assign ad_bits = !r_r.seen_lo ? AD_VCC :
		!r_r.seen_hi ? AD_GND :
		r_r.ne_sda ? AD_SCL : AD_SDA;
	assign addr_ok = link_byte[7:3] == TARGET_ADDR_HI &&
		link_byte[2:1] == ad_bits &&
		link_byte[0] == 1'b0;

	assign wr_en = r_r.st == ST_BYTE && new_byte && r_r.kind == K_DATA;
	assign duty_idx = 5'(r_r.ptr - REG_DUTY_FIRST);
	assign ctl_idx = 5'(r_r.ptr - REG_CTRL_FIRST);
	assign outputs_on = r_r.sw_shutdown_n & r_r.gen & r_r.hw_s;

	// ---------------------------------------------------------------
	// next state: protocol, register writes and channel drive
	// ---------------------------------------------------------------
	always_comb
	begin
		r_nxt = r_r;
		// every pin passes two flops before use
		r_nxt.scl_m = i_scl;
		r_nxt.scl_s = r_r.scl_m;
		r_nxt.sda_m = i_sda;
		r_nxt.sda_s = r_r.sda_m;
		r_nxt.sda_d = r_r.sda_s;
		r_nxt.sel_m = i_addr_sel;
		r_nxt.sel_s = r_r.sel_m;
		r_nxt.hw_m = i_hw_shutdown_pin_n;
		r_nxt.hw_s = r_r.hw_m;
		r_nxt.tog_m = link_tog;
		r_nxt.tog_s = r_r.tog_m;
		r_nxt.tog_d = r_r.tog_s;

		// strap observation during a frame
		if (r_r.sel_s)
			r_nxt.seen_hi = 1'b1;
		else
			r_nxt.seen_lo = 1'b1;
		if (r_r.sel_s != r_r.sda_s)
			r_nxt.ne_sda = 1'b1;

		// release the link clear once the clock has gone low
		if (r_r.clr && !r_r.scl_s)
			r_nxt.clr = 1'b0;

		unique case (r_r.st)
			ST_IDLE:
			begin
				r_nxt.sda_oe = 1'b0;
			end
			ST_BYTE:
			begin
				if (new_byte)
				begin
					if (r_r.kind == K_ADDR)
						r_nxt.st = addr_ok ? ST_ACK_LOW : ST_SKIP;
					else
						r_nxt.st = ST_ACK_LOW;
					if (r_r.kind == K_REG)
						r_nxt.ptr = link_byte;
					// stepping as the acknowledge begins; stuck at the top
					if (r_r.kind == K_DATA && r_r.ptr != PTR_MAX)
						r_nxt.ptr = r_r.ptr + 8'h01;
				end
			end
			ST_ACK_LOW:
			begin
				// drive only after the clock has fallen from bit 7
				if (!r_r.scl_s)
				begin
					r_nxt.sda_oe = 1'b1;
					r_nxt.st = ST_ACK_HIGH;
				end
			end
			ST_ACK_HIGH:
			begin
				if (r_r.scl_s)
					r_nxt.st = ST_ACK_END;
			end
			ST_ACK_END:
			begin
				if (!r_r.scl_s)
				begin
					r_nxt.sda_oe = 1'b0;
					r_nxt.st = ST_BYTE;
					r_nxt.kind = r_r.kind == K_ADDR ? K_REG : K_DATA;
				end
			end
			ST_SKIP:
			begin
				r_nxt.sda_oe = 1'b0;
			end
			default:
			begin
				r_nxt.st = ST_IDLE;
				r_nxt.sda_oe = 1'b0;
			end
		endcase

		// register writes, undefined offsets fall through untouched
		if (wr_en)
		begin
			if (r_r.ptr == REG_SHUTDOWN)
				r_nxt.sw_shutdown_n = link_byte[SD_BIT];
			if (r_r.ptr >= REG_DUTY_FIRST && r_r.ptr <= REG_DUTY_LAST)
				r_nxt.duty_p[duty_idx] = link_byte;
			if (r_r.ptr >= REG_CTRL_FIRST && r_r.ptr <= REG_CTRL_LAST)
				r_nxt.ctl_p[ctl_idx] = link_byte[2:0];
			if (r_r.ptr == REG_LATCH && link_byte == TRIGGER_VALUE)
			begin
				r_nxt.duty_a = r_r.duty_p;
				r_nxt.ctl_a = r_r.ctl_p;
			end
			if (r_r.ptr == REG_GLOBAL_EN)
				r_nxt.gen = link_byte[GEN_BIT];
			if (r_r.ptr == REG_SOFT_RESET && link_byte == TRIGGER_VALUE)
			begin
				// protocol state untouched so this byte is still acked
				r_nxt.sw_shutdown_n = RST_SD_N;
				r_nxt.gen = RST_GEN;
				r_nxt.duty_p = {NUM_CH{RST_DUTY}};
				r_nxt.duty_a = {NUM_CH{RST_DUTY}};
				r_nxt.ctl_p = {NUM_CH{RST_CTL}};
				r_nxt.ctl_a = {NUM_CH{RST_CTL}};
			end
		end

		// start and stop override any state, repeated start included
		if (start_det)
		begin
			r_nxt.st = ST_BYTE;
			r_nxt.kind = K_ADDR;
			r_nxt.clr = 1'b1;
			r_nxt.sda_oe = 1'b0;
			r_nxt.seen_lo = ~r_r.sel_s;
			r_nxt.seen_hi = r_r.sel_s;
			r_nxt.ne_sda = 1'b0;
		end
		else if (stop_det)
		begin
			r_nxt.st = ST_IDLE;
			r_nxt.sda_oe = 1'b0;
		end

		// free running pwm, on while the count is below the duty
		r_nxt.pwm_cnt = r_r.pwm_cnt + 8'h01;
		for (int i = 0; i < NUM_CH; i++)
		begin
			r_nxt.led[i] = outputs_on & r_r.ctl_a[i][CTL_ON_BIT] &
				(r_r.pwm_cnt < r_r.duty_a[i]);
			r_nxt.scale[i] = r_r.ctl_a[i][CTL_SCALE_LSB +: 2];
		end
	end

	// state register; registers keep values across every shutdown
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			r_r <= '0;
			r_r.scl_m <= 1'b1;
			r_r.scl_s <= 1'b1;
			r_r.sda_m <= 1'b1;
			r_r.sda_s <= 1'b1;
			r_r.sda_d <= 1'b1;
		end
		else
		begin
			r_r <= r_nxt;
		end
	end

	// open drain: only ever pulls low
	assign o_sda = 1'b0;
	assign o_sda_oe = r_r.sda_oe;
	assign o_led_channel_outputs = r_r.led;
	assign o_current_scale_sel = r_r.scale;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	a_oe_only_ack: assert property (o_sda_oe |->
		r_r.st == ST_ACK_HIGH || r_r.st == ST_ACK_END)
		else $error("data pulled low outside acknowledge");
	a_read_refused: assert property (new_byte &&
		r_r.st == ST_BYTE && r_r.kind == K_ADDR && link_byte[0] &&
		!start_det && !stop_det |=> r_r.st == ST_SKIP ##1 !o_sda_oe)
		else $error("read request was not refused");
	a_addr_mismatch: assert property (new_byte &&
		r_r.st == ST_BYTE && r_r.kind == K_ADDR && !start_det &&
		link_byte[7:3] != TARGET_ADDR_HI && !stop_det |=> r_r.st == ST_SKIP)
		else $error("foreign address accepted");
	a_start_restart: assert property (start_det |=>
		r_r.st == ST_BYTE && r_r.kind == K_ADDR && r_r.clr)
		else $error("start did not restart address phase");
	a_stop_idle: assert property (stop_det && !start_det |=>
		r_r.st == ST_IDLE && !o_sda_oe)
		else $error("stop did not end transfer");
	a_ptr_step: assert property (wr_en && !start_det &&
		r_r.ptr != PTR_MAX |=> r_r.ptr == $past(r_r.ptr) + 8'h01)
		else $error("pointer did not step by one");
	a_latch_copy: assert property (wr_en &&
		r_r.ptr == REG_LATCH && link_byte == TRIGGER_VALUE |=>
		r_r.duty_a == $past(r_r.duty_p) && r_r.ctl_a == $past(r_r.ctl_p))
		else $error("latch write did not move pending values");
	a_shutdown_dark: assert property (!r_r.sw_shutdown_n |=>
		o_led_channel_outputs == '0)
		else $error("channel lit during shutdown");
	a_duty_zero: assert property (r_r.duty_a[0] == RST_DUTY |=>
		!o_led_channel_outputs[0])
		else $error("channel lit at zero duty");
	a_soft_reset: assert property (wr_en &&
		r_r.ptr == REG_SOFT_RESET && link_byte == TRIGGER_VALUE |=>
		r_r.duty_p == '0 && !r_r.sw_shutdown_n && !r_r.gen)
		else $error("soft reset left registers set");

	c_addr_ack: cover property (r_r.kind == K_ADDR &&
		r_r.st == ST_ACK_HIGH);
	c_latch: cover property (wr_en && r_r.ptr == REG_LATCH &&
		link_byte == TRIGGER_VALUE);
	c_soft_reset: cover property (wr_en && r_r.ptr == REG_SOFT_RESET);
	c_led_on: cover property (o_led_channel_outputs[0]);

endmodule

/* rtl/lwr_pkg.sv */
// constants and types shared by the led driver write-only register target
package lwr_pkg;

	// ---------------------------------------------------------------
	// channel and bus figures
	// ---------------------------------------------------------------
	localparam int NUM_CH = 28;
	localparam logic [4:0] TARGET_ADDR_HI = 5'h0F;
	localparam logic [1:0] AD_GND = 2'h0;
	localparam logic [1:0] AD_VCC = 2'h3;
	localparam logic [1:0] AD_SCL = 2'h1;
	localparam logic [1:0] AD_SDA = 2'h2;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_SHUTDOWN = 8'h00;
	localparam logic [7:0] REG_DUTY_FIRST = 8'h05;
	localparam logic [7:0] REG_DUTY_LAST = 8'h20;
	localparam logic [7:0] REG_LATCH = 8'h25;
	localparam logic [7:0] REG_CTRL_FIRST = 8'h2A;
	localparam logic [7:0] REG_CTRL_LAST = 8'h45;
	localparam logic [7:0] REG_GLOBAL_EN = 8'h4A;
	localparam logic [7:0] REG_SOFT_RESET = 8'h4F;
	localparam logic [7:0] PTR_MAX = 8'hFF;

	// ---------------------------------------------------------------
	// field positions, trigger value and reset values
	// ---------------------------------------------------------------
	localparam int SD_BIT = 0;
	localparam int GEN_BIT = 0;
	localparam int CTL_ON_BIT = 0;
	localparam int CTL_SCALE_LSB = 1;
	localparam logic [7:0] TRIGGER_VALUE = 8'h00;
	localparam logic RST_SD_N = 1'h0;
	localparam logic RST_GEN = 1'h0;
	localparam logic [7:0] RST_DUTY = 8'h00;
	localparam logic [2:0] RST_CTL = 3'h0;

	// ---------------------------------------------------------------
	// protocol states and byte kinds
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_BYTE = 3'b001,
		ST_ACK_LOW = 3'b010,
		ST_ACK_HIGH = 3'b011,
		ST_ACK_END = 3'b100,
		ST_SKIP = 3'b101
	} lwr_st_e;

	typedef enum logic [1:0] {
		K_ADDR = 2'b00,
		K_REG = 2'b01,
		K_DATA = 2'b10
	} lwr_kind_e;

endpackage

/* tb/led_driver_i2c_write_regs_tb_top.sv */
// self-checking bench for the led driver write-only register target
module led_driver_i2c_write_regs_tb_top
	import lwr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ---------------------------------------------------------------
	// signals, wired-and data line and strap selection
	// ---------------------------------------------------------------
	localparam int CYCLE_LIMIT = 80000;
	logic clock;
	logic rst;
	logic scl;
	logic host_low;
	logic dev_sda;
	logic dev_oe;
	logic sda_wire;
	logic addr_sel;
	logic hw_n;
	logic [1:0] strap_mode;
	logic [NUM_CH-1:0] led_out;
	logic [2*NUM_CH-1:0] scale_out;
	logic ack;
	logic [8:0] n_on;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;

	// open drain with pull-up: any party pulling wins
	assign sda_wire = (host_low || (dev_oe && !dev_sda)) ? 1'b0 : 1'b1;
	// strap pin tied to ground, supply, clock line or data line
	assign addr_sel = (strap_mode == AD_GND) ? 1'b0 :
		(strap_mode == AD_VCC) ? 1'b1 :
		(strap_mode == AD_SCL) ? scl : sda_wire;

	lwr_host_model host
	(
		.i_sda(sda_wire),
		.o_scl(scl),
		.o_sda_low(host_low)
	);

	lwr_led_regs uut
	(
		.i_clock(clock),
		.i_rst(rst),
		.i_scl(scl),
		.i_sda(sda_wire),
		.o_sda(dev_sda),
		.o_sda_oe(dev_oe),
		.i_addr_sel(addr_sel),
		.i_hw_shutdown_pin_n(hw_n),
		.o_led_channel_outputs(led_out),
		.o_current_scale_sel(scale_out)
	);

	// ---------------------------------------------------------------
	// clock and hang guard
	// ---------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever
			#25 clock = ~clock;
	end

	// a stuck handshake would otherwise spin forever
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == CYCLE_LIMIT)
		begin
			n_fail++;
			print_verdict();
		end
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic print_verdict();
	begin
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
	begin
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask

	// address-only frame, answer handed back
	task automatic probe(input logic [7:0] a, output logic got);
	begin
		host.start_cond();
		host.send_byte(a, got);
		host.stop_cond();
	end
	endtask

	// one write frame: target address, register address, data burst
	task automatic wr_regs(input logic [7:0] ra, input logic [7:0] d[$]);
		logic a;
	begin
		host.start_cond();
		host.send_byte({TARGET_ADDR_HI, strap_mode, 1'b0}, a);
		check("address ack", a, 1);
		host.send_byte(ra, a);
		check("register ack", a, 1);
		foreach (d[i])
		begin
			host.send_byte(d[i], a);
			check("data ack", a, 1);
		end
		host.stop_cond();
	end
	endtask

	// pwm counter period is 256 cycles, so on-cycles equal the duty
	task automatic on_count(input int ch, output logic [8:0] n);
	begin
		n = 9'h000;
		repeat (256)
		begin
			@(posedge clock);
			#1;
			n = n + 9'(led_out[ch]);
		end
	end
	endtask

	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		hw_n = 1'b1;
		strap_mode = AD_GND;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (8) @(posedge clock);
		check("scale", scale_out, 0);
		check("leds", led_out, 0);
		$display("test reset_defaults done");

		// every strap wiring, a foreign address and a read request
		for (int m = 0; m < 4; m++)
		begin
			@(posedge clock) strap_mode <= 2'(m);
			probe({TARGET_ADDR_HI, 2'(m), 1'b0}, ack);
			check("own address", ack, 1);
			probe({TARGET_ADDR_HI, ~2'(m), 1'b0}, ack);
			check("other address", ack, 0);
			probe({TARGET_ADDR_HI, 2'(m), 1'b1}, ack);
			check("read request", ack, 0);
		end
		@(posedge clock) strap_mode <= AD_GND;
		$display("test strap_address done");

		// control burst stays pending until the latch gets all zeros
		wr_regs(REG_CTRL_FIRST, '{8'h01, 8'h03, 8'h05, 8'h07});
		check("scale pending", scale_out, 0);
		wr_regs(REG_LATCH, '{8'h01});
		check("scale nonzero latch", scale_out, 0);
		wr_regs(REG_LATCH, '{8'h00});
		check("scale latched", scale_out, 56'hE4);
		$display("test pending_update done");

		// duty, shutdown and global enable gating
		wr_regs(REG_DUTY_FIRST, '{8'h40});
		wr_regs(REG_DUTY_LAST, '{8'hFF});
		wr_regs(REG_CTRL_LAST, '{8'h01});
		wr_regs(REG_LATCH, '{8'h00});
		on_count(0, n_on);
		check("ch1 in shutdown", n_on, 0);
		wr_regs(REG_SHUTDOWN, '{8'h01});
		on_count(0, n_on);
		check("ch1 global off", n_on, 0);
		wr_regs(REG_GLOBAL_EN, '{8'h01});
		on_count(0, n_on);
		check("ch1 duty", n_on, 64);
		on_count(NUM_CH - 1, n_on);
		check("ch28 duty", n_on, 255);
		on_count(1, n_on);
		check("ch2 zero duty", n_on, 0);
		@(posedge clock) hw_n <= 1'b0;
		// pin crosses two sync flops and the output register first
		repeat (4) @(posedge clock);
		on_count(0, n_on);
		check("ch1 pin shutdown", n_on, 0);
		@(posedge clock) hw_n <= 1'b1;
		wr_regs(REG_SHUTDOWN, '{8'h00});
		on_count(0, n_on);
		check("ch1 soft shutdown", n_on, 0);
		wr_regs(REG_SHUTDOWN, '{8'h01});
		on_count(0, n_on);
		check("ch1 kept duty", n_on, 64);
		$display("test duty_gating done");

		// holes in the map and a burst running off the top
		wr_regs(8'h01, '{8'hFF});
		wr_regs(8'hFE, '{8'h11, 8'h00, 8'h00});
		on_count(0, n_on);
		check("ch1 after holes", n_on, 64);
		check("scale after holes", scale_out, 56'hE4);
		$display("test unmapped done");

		// soft reset only on an all-zero write
		wr_regs(REG_SOFT_RESET, '{8'h01});
		check("scale nonzero reset", scale_out, 56'hE4);
		wr_regs(REG_SOFT_RESET, '{8'h00});
		check("scale soft reset", scale_out, 0);
		on_count(0, n_on);
		check("ch1 soft reset", n_on, 0);
		$display("test soft_reset done");
		print_verdict();
	end
endmodule

/* tb/lwr_host_model.sv */
// host-side two-wire master model driving serial clock and data
module lwr_host_model
(
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	timeunit 1ns;
	timeprecision 1ns;

	// ---------------------------------------------------------------
	// idle bus: clock stands high, data released to the pull-up
	// ---------------------------------------------------------------
	initial
	begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// ---------------------------------------------------------------
	// frame primitives, slow enough for the two-flop pin samplers
	// ---------------------------------------------------------------
	// release data first so a repeated start cannot look like a stop
	task automatic start_cond();
	begin
		o_sda_low = 1'b0;
		#300;
		o_scl = 1'b1;
		#1300;
		o_sda_low = 1'b1;
		#700;
		o_scl = 1'b0;
	end
	endtask

	// data moves only while the clock is low
	task automatic clock_bit(input logic b, output logic seen);
	begin
		#300;
		o_sda_low = ~b;
		#1000;
		o_scl = 1'b1;
		#400;
		seen = i_sda;
		#400;
		o_scl = 1'b0;
	end
	endtask

	// eight bits msb first, then a released ninth bit for the answer
	task automatic send_byte(input logic [7:0] v, output logic ack);
		logic s;
	begin
		for (int i = 7; i >= 0; i--)
			clock_bit(v[i], s);
		clock_bit(1'b1, s);
		ack = ~s;
	end
	endtask

	// data rises with the clock high, then bus free time
	task automatic stop_cond();
	begin
		#300;
		o_sda_low = 1'b1;
		#1000;
		o_scl = 1'b1;
		#700;
		o_sda_low = 1'b0;
		#1300;
	end
	endtask
endmodule
